// ===== logic/switch_csr_indirect_access.sv
// Indirect access engine from the host register port to the switch fabric register array.
module switch_csr_indirect_access
    import csr_bridge_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [LANES-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic fabric_req_valid,
    input wire logic fabric_req_ready,
    output fabric_req_t fabric_req,
    input wire logic fabric_rsp_valid,
    input wire logic [DATA_W-1:0] fabric_rsp_data,
    output logic transfer_pending
);

    logic wr_strobe;
    reg_write_t wr_access;
    logic rd_strobe;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_value;

    logic direction_select;
    logic addr_step_up_enable;
    logic addr_step_down_enable;
    logic [LANES-1:0] lane_write_mask;
    logic [INDEX_W-1:0] target_index;
    logic [DATA_W-1:0] written_data;
    logic [DATA_W-1:0] fetched_data;
    engine_state_t state;
    step_t post_step;
    logic merge_read;

    logic [DATA_W-1:0] command_word;
    logic [DATA_W-1:0] command_merged;
    logic command_write;
    logic data_write;
    logic data_read;
    step_t step_now;
    logic start;
    logic done;
    logic next_direction;
    logic [LANES-1:0] next_mask;
    logic [INDEX_W-1:0] next_index;
    logic [DATA_W-1:0] next_written;

    axil_reg_slave bus_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_strobe(wr_strobe),
        .wr_access(wr_access),
        .rd_strobe(rd_strobe),
        .rd_addr(rd_addr),
        .rd_value(rd_value)
    );

    // The reserved field always reads as zero.
    always_comb begin
        command_word = DATA_RESET;
        command_word[PENDING_BIT] = transfer_pending;
        command_word[DIRECTION_BIT] = direction_select;
        command_word[STEP_UP_BIT] = addr_step_up_enable;
        command_word[STEP_DOWN_BIT] = addr_step_down_enable;
        command_word[MASK_LSB +: LANES] = lane_write_mask;
        command_word[INDEX_LSB +: INDEX_W] = target_index;
    end

    assign command_merged = merge_lanes(command_word, wr_access.data, wr_access.strb);

    // Writes and data reads made while a transfer is pending change nothing in the engine, so a misbehaving host cannot
    // corrupt the request or launch a second transfer on top of the first.
    assign command_write = wr_strobe && (decode_reg(wr_access.addr) == SEL_CMD)
                           && !transfer_pending;
    assign data_write = wr_strobe && (decode_reg(wr_access.addr) == SEL_DATA)
                        && !transfer_pending;
    assign data_read = rd_strobe && (decode_reg(rd_addr) == SEL_DATA) && !transfer_pending;

    // Step-up wins whenever both enables are set.
    always_comb begin
        if (addr_step_up_enable) begin
            step_now = STEP_UP;
        end else if (addr_step_down_enable) begin
            step_now = STEP_DOWN;
        end else begin
            step_now = STEP_NONE;
        end
    end

    assign start = (command_write && command_merged[PENDING_BIT])
                   || (data_write && step_now != STEP_NONE)
                   || (data_read && step_now != STEP_NONE);

    assign done = (state == ST_WAIT) && fabric_rsp_valid && !merge_read;

    always_comb begin
        next_direction = direction_select;
        next_mask = lane_write_mask;
        next_index = target_index;
        next_written = written_data;
        if (command_write) begin
            next_direction = command_merged[DIRECTION_BIT];
            next_mask = command_merged[MASK_LSB +: LANES];
            next_index = command_merged[INDEX_LSB +: INDEX_W];
        end
        if (data_write) begin
            next_written = merge_lanes(written_data, wr_access.data, wr_access.strb);
        end
        // The index moves before the fetch so the read lands on the next register in the step direction.
        if (data_read && step_now == STEP_UP) begin
            next_index = target_index + INDEX_ONE;
        end else if (data_read && step_now == STEP_DOWN) begin
            next_index = target_index - INDEX_ONE;
        end else if (done && post_step == STEP_UP) begin
            next_index = target_index + INDEX_ONE;
        end else if (done && post_step == STEP_DOWN) begin
            next_index = target_index - INDEX_ONE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            direction_select <= DIRECTION_RESET;
            addr_step_up_enable <= STEP_UP_RESET;
            addr_step_down_enable <= STEP_DOWN_RESET;
            lane_write_mask <= MASK_RESET;
        end else if (command_write) begin
            direction_select <= next_direction;
            addr_step_up_enable <= command_merged[STEP_UP_BIT];
            addr_step_down_enable <= command_merged[STEP_DOWN_BIT];
            lane_write_mask <= next_mask;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            target_index <= INDEX_RESET;
        end else begin
            target_index <= next_index;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            written_data <= DATA_RESET;
        end else begin
            written_data <= next_written;
        end
    end

    // Set and clear never meet: a start is only accepted while nothing is pending.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            transfer_pending <= PENDING_RESET;
        end else if (start) begin
            transfer_pending <= 1'b1;
        end else if (done) begin
            transfer_pending <= 1'b0;
        end
    end

    // Only a step-mode data write moves the index after completion; reads moved it already.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            post_step <= STEP_NONE;
        end else if (start) begin
            post_step <= data_write ? step_now : STEP_NONE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fetched_data <= DATA_RESET;
        end else if (done && !fabric_req.write) begin
            fetched_data <= fabric_rsp_data;
        end
    end

    // A partial-lane write becomes read, merge, full write, so the fabric never sees
    // garbage in the unselected lanes; the cost is one extra fabric round trip.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            merge_read <= 1'b0;
            fabric_req <= '{index: INDEX_RESET, write: 1'b0, data: DATA_RESET, strb: MASK_RESET};
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= ST_ISSUE;
                        merge_read <= !next_direction && (next_mask != ALL_LANES);
                        fabric_req.index <= next_index;
                        fabric_req.write <= !next_direction
                                            && (next_mask == ALL_LANES);
                        fabric_req.data <= next_written;
                        fabric_req.strb <= ALL_LANES;
                    end
                end
                ST_ISSUE: begin
                    if (fabric_req_ready) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (fabric_rsp_valid && merge_read) begin
                        state <= ST_ISSUE;
                        merge_read <= 1'b0;
                        fabric_req.write <= 1'b1;
                        fabric_req.data <= merge_lanes(fabric_rsp_data, fabric_req.data,
                                                       lane_write_mask);
                    end else if (fabric_rsp_valid) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    merge_read <= 1'b0;
                end
            endcase
        end
    end

    assign fabric_req_valid = (state == ST_ISSUE);

    always_comb begin
        case (decode_reg(rd_addr))
            SEL_CMD: rd_value = command_word;
            SEL_DATA: rd_value = direction_select ? fetched_data : written_data;
            default: rd_value = DATA_RESET;
        endcase
    end

endmodule

// ===== inc/csr_bridge_pkg.sv
// Shared constants, types and helpers for the fabric register indirect access engine.
package csr_bridge_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int INDEX_W = 16;

    localparam logic [ADDR_W-1:0] DATA_WORD_OFFSET = 12'h1ac;
    localparam logic [ADDR_W-1:0] COMMAND_WORD_OFFSET = 12'h1b0;

    localparam int PENDING_BIT = 31;
    localparam int DIRECTION_BIT = 30;
    localparam int STEP_UP_BIT = 29;
    localparam int STEP_DOWN_BIT = 28;
    localparam int RESERVED_LSB = 20;
    localparam int RESERVED_W = 8;
    localparam int MASK_LSB = 16;
    localparam int INDEX_LSB = 0;

    localparam logic PENDING_RESET = 1'b0;
    localparam logic DIRECTION_RESET = 1'b0;
    localparam logic STEP_UP_RESET = 1'b0;
    localparam logic STEP_DOWN_RESET = 1'b0;
    localparam logic [LANES-1:0] MASK_RESET = 4'h0;
    localparam logic [INDEX_W-1:0] INDEX_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
    localparam logic [LANES-1:0] ALL_LANES = 4'hf;
    localparam logic [INDEX_W-1:0] INDEX_ONE = 16'h0001;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_DATA = 2'b01,
        SEL_CMD = 2'b10
    } reg_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT = 2'b11
    } engine_state_t;

    typedef enum logic [1:0] {
        STEP_NONE = 2'b00,
        STEP_UP = 2'b01,
        STEP_DOWN = 2'b10
    } step_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] strb;
    } reg_write_t;

    typedef struct packed {
        logic [INDEX_W-1:0] index;
        logic write;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] strb;
    } fabric_req_t;

    // Word-aligned decode; the two low address bits are ignored.
    function automatic reg_sel_t decode_reg(input logic [ADDR_W-1:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        if (addr[ADDR_W-1:2] == DATA_WORD_OFFSET[ADDR_W-1:2]) begin
            sel = SEL_DATA;
        end else if (addr[ADDR_W-1:2] == COMMAND_WORD_OFFSET[ADDR_W-1:2]) begin
            sel = SEL_CMD;
        end
        return sel;
    endfunction

    // Lane n of the mask selects bits 8n+7 down to 8n of the fresh value.
    function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old_value,
                                                      input logic [DATA_W-1:0] new_value,
                                                      input logic [LANES-1:0] mask);
        logic [DATA_W-1:0] result;
        result = old_value;
        for (int lane = 0; lane < LANES; lane++) begin
            if (mask[lane]) begin
                result[lane*8 +: 8] = new_value[lane*8 +: 8];
            end
        end
        return result;
    endfunction

endpackage

// ===== logic/axil_reg_slave.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes.
module axil_reg_slave
    import csr_bridge_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [LANES-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_strobe,
    output reg_write_t wr_access,
    output logic rd_strobe,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic [DATA_W-1:0] rd_value
);

    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [LANES-1:0] w_strb;
    logic wr_fire;
    logic ar_fire;

    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign ar_fire = s_axi_arvalid && s_axi_arready;
    assign wr_access = '{addr: aw_addr, data: w_data, strb: w_strb};
    assign wr_strobe = wr_fire && (decode_reg(aw_addr) != SEL_NONE);
    assign rd_strobe = ar_fire && (decode_reg(s_axi_araddr) != SEL_NONE);
    assign rd_addr = s_axi_araddr;

    // Address and data are held separately so the master may offer them in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= DATA_RESET;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (decode_reg(aw_addr) != SEL_NONE) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= DATA_RESET;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            if (decode_reg(s_axi_araddr) != SEL_NONE) begin
                s_axi_rdata <= rd_value;
                s_axi_rresp <= RESP_OKAY;
            end else begin
                s_axi_rdata <= DATA_RESET;
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ===== testbench/fabric_model.sv
// Behavioural model of the switch fabric register array on the far side of the engine.
module fabric_model
    import csr_bridge_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic slow,
    input wire logic fabric_req_valid,
    output logic fabric_req_ready,
    input wire fabric_req_t fabric_req,
    output logic fabric_rsp_valid,
    output logic [DATA_W-1:0] fabric_rsp_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] mem [256];
    fabric_req_t held;
    logic busy, tick;
    logic [3:0] cnt;
    // A slow fabric accepts only every other cycle and answers sixteen cycles late.
    assign fabric_req_ready = !busy && (!slow || tick);
    always_ff @(posedge aclk) begin
        tick <= !tick;
        fabric_rsp_valid <= 1'b0;
        // Outside an answer the data lines toggle, so a stale value is never mistaken for data.
        fabric_rsp_data <= ~fabric_rsp_data;
        if (!aresetn) begin
            busy <= 1'b0;
            tick <= 1'b0;
            cnt <= 4'h0;
            fabric_rsp_data <= 32'h0000_0000;
            for (int i = 0; i < 256; i++) mem[i] <= {4{8'(i)}};
        end else if (fabric_req_valid && fabric_req_ready) begin
            busy <= 1'b1;
            held <= fabric_req;
            cnt <= 4'h0;
        end else if (busy) begin
            cnt <= cnt + 4'h1;
            if (!slow || cnt == 4'hf) begin
                busy <= 1'b0;
                fabric_rsp_valid <= 1'b1;
                for (int b = 0; b < LANES; b++) begin
                    if (held.write && held.strb[b]) begin
                        mem[held.index[7:0]][b*8 +: 8] <= held.data[b*8 +: 8];
                    end
                end
                if (!held.write) fabric_rsp_data <= mem[held.index[7:0]];
            end
        end
    end
endmodule

// ===== testbench/switch_csr_indirect_access_assertions.sv
// Concurrent checks on the ports of the fabric register indirect access engine.
module switch_csr_indirect_access_assertions
    import csr_bridge_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_arready,
    input wire logic fabric_req_valid,
    input wire logic fabric_req_ready,
    input wire fabric_req_t fabric_req,
    input wire logic fabric_rsp_valid,
    input wire logic transfer_pending
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_taken;
        fabric_req_valid && fabric_req_ready;
    endsequence
    sequence s_stall;
        fabric_req_valid && !fabric_req_ready;
    endsequence
    sequence s_started;
        $rose(transfer_pending);
    endsequence
    AST_REQ_HOLD: assert property (s_stall |=> fabric_req_valid && $stable(fabric_req))
        else $error("fabric request dropped or changed before acceptance");
    AST_REQ_ONCE: assert property (s_taken |=> !fabric_req_valid)
        else $error("fabric request repeated after acceptance");
    AST_REQ_PENDING: assert property (fabric_req_valid |-> transfer_pending)
        else $error("fabric request without pending flag");
    AST_START_CAUSE: assert property (s_started |-> $rose(s_axi_bvalid) || $rose(s_axi_rvalid))
        else $error("pending flag set without a host access");
    AST_START_ISSUE: assert property (s_started |-> ##[0:1] fabric_req_valid)
        else $error("started transfer not issued to the fabric");
    AST_PEND_HOLD: assert property (transfer_pending && !fabric_rsp_valid |=> transfer_pending)
        else $error("pending flag cleared before fabric completion");
    AST_PEND_CLEAR: assert property ($fell(transfer_pending) |-> $past(fabric_rsp_valid))
        else $error("pending flag cleared without a fabric answer");
    AST_FULL_LANES: assert property (fabric_req_valid |-> fabric_req.strb == ALL_LANES)
        else $error("fabric request with partial lanes");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while read data waits");
endmodule

bind switch_csr_indirect_access switch_csr_indirect_access_assertions u_chk (
    .aclk, .aresetn, .s_axi_bvalid, .s_axi_rvalid, .s_axi_arready, .fabric_req_valid,
    .fabric_req_ready, .fabric_req, .fabric_rsp_valid, .transfer_pending
);

// ===== testbench/switch_csr_indirect_access_tb.sv
// Self-checking bench for the fabric register indirect access engine.
module switch_csr_indirect_access_tb
    import csr_bridge_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [DATA_W-1:0] PEND = 32'h8000_0000;
    localparam logic [DATA_W-1:0] DIR = 32'h4000_0000;
    localparam logic [DATA_W-1:0] UP = 32'h2000_0000;
    localparam logic [DATA_W-1:0] DN = 32'h1000_0000;
    localparam logic [DATA_W-1:0] FULL = 32'h000f_0000;
    localparam logic [ADDR_W-1:0] CMD = COMMAND_WORD_OFFSET;
    localparam logic [ADDR_W-1:0] DAT = DATA_WORD_OFFSET;
    logic aclk, aresetn, slow;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, fabric_rsp_data, v;
    logic [LANES-1:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic fabric_req_valid, fabric_req_ready, fabric_rsp_valid, transfer_pending;
    fabric_req_t fabric_req;
    logic [DATA_W-1:0] exp_mem [256];
    logic [3:0] masks [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h0};
    int error_cnt = 0;
    int n_tests = 0, cycles = 0;

    switch_csr_indirect_access u_switch_csr_indirect_access (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fabric_req_valid, .fabric_req_ready,
        .fabric_req, .fabric_rsp_valid, .fabric_rsp_data, .transfer_pending
    );
    fabric_model u_fabric_model (
        .aclk, .aresetn, .slow, .fabric_req_valid, .fabric_req_ready, .fabric_req,
        .fabric_rsp_valid, .fabric_rsp_data
    );

    always #2 aclk = ~aclk;

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // The run is a few hundred cycles; the ceiling only catches a hang.
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] e);
        n_tests++;
        if (got !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask

    task automatic chkr(input logic [1:0] got, input logic [1:0] e);
        n_tests++;
        if (got !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t resp got=%h exp=%h", $time, got, e);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [1:0] rs);
        logic da, dw, ha, hw;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        {da, dw} = 2'b00;
        while (!(da && dw)) begin
            @(negedge aclk);
            ha = s_axi_awready && !da;
            hw = s_axi_wready && !dw;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            da = da || ha;
            dw = dw || hw;
        end
        ha = 1'b0;
        while (!ha) begin
            @(negedge aclk);
            ha = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge aclk);
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                      output logic [1:0] rs);
        logic h;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        h = 1'b0;
        while (!h) begin
            @(negedge aclk);
            h = s_axi_arready;
            @(posedge aclk);
        end
        s_axi_arvalid <= 1'b0;
        h = 1'b0;
        while (!h) begin
            @(negedge aclk);
            h = s_axi_rvalid;
            d = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
        end
        s_axi_rready <= 1'b0;
    endtask

    task automatic wrok(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [1:0] rs;
        wr(a, d, rs);
        chkr(rs, RESP_OKAY);
    endtask

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        logic [DATA_W-1:0] d;
        logic [1:0] rs;
        rd(a, d, rs);
        chk(d, e);
        chkr(rs, RESP_OKAY);
    endtask

    task automatic pend(input logic [DATA_W-1:0] e);
        @(negedge aclk);
        chk(32'(transfer_pending), e);
    endtask

    // Waits for the pending flag to drop, bounded well above the slow fabric's latency.
    task automatic idle();
        int n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (transfer_pending !== 1'b0 && n < 64);
        chk(32'(transfer_pending), 32'h0000_0000);
    endtask

    task automatic fab(input logic [7:0] i, input logic [DATA_W-1:0] e);
        chk(u_fabric_model.mem[i], e);
        exp_mem[i] = e;
    endtask

    function automatic logic [DATA_W-1:0] mix(input logic [DATA_W-1:0] o,
                                              input logic [DATA_W-1:0] n, input logic [3:0] m);
        for (int i = 0; i < 4; i++) if (m[i]) o[i*8 +: 8] = n[i*8 +: 8];
        return o;
    endfunction

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        slow = 1'b0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = ALL_LANES;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        for (int i = 0; i < 256; i++) exp_mem[i] = {4{8'(i)}};
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rdchk(CMD, 32'h0000_0000);
        rdchk(DAT, DATA_RESET);
        rd(12'h1b4, v, r);
        chkr(r, RESP_SLVERR);
        wr(12'h1b4, 32'h1234_5678, r);
        chkr(r, RESP_SLVERR);
        wrok(DAT, 32'h1122_3344);
        pend(32'h0000_0000);
        wrok(CMD, PEND | FULL | 32'h0000_0005);
        idle();
        fab(8'h05, 32'h1122_3344);
        rdchk(CMD, FULL | 32'h0000_0005);
        wrok(CMD, PEND | DIR | 32'h0000_0007);
        idle();
        rdchk(DAT, exp_mem[7]);
        wrok(CMD, 32'h0000_0007);
        rdchk(DAT, 32'h1122_3344);
        foreach (masks[k]) begin
            wrok(DAT, 32'haabb_ccdd);
            wrok(CMD, PEND | {12'h000, masks[k], 16'h0009});
            idle();
            fab(8'h09, mix(exp_mem[9], 32'haabb_ccdd, masks[k]));
        end
        slow <= 1'b1;
        wrok(CMD, UP | FULL | 32'h0000_fffe);
        for (int i = 0; i < 3; i++) begin
            wrok(DAT, 32'h5500_0000 + 32'(i));
            pend(32'h0000_0001);
            // A data write while busy is dropped.
            if (i == 0) wrok(DAT, 32'hdead_beef);
            idle();
            fab(8'hfe + 8'(i), 32'h5500_0000 + 32'(i));
        end
        rdchk(CMD, UP | FULL | 32'h0000_0001);
        slow <= 1'b0;
        wrok(CMD, UP | DN | FULL | 32'h0000_0010);
        wrok(DAT, 32'h6600_0010);
        idle();
        fab(8'h10, 32'h6600_0010);
        rdchk(CMD, UP | DN | FULL | 32'h0000_0011);
        wrok(CMD, DN | FULL | 32'h0000_0001);
        for (int i = 0; i < 2; i++) begin
            wrok(DAT, 32'h7700_0000 + 32'(i));
            idle();
            fab(8'h01 - 8'(i), 32'h7700_0000 + 32'(i));
        end
        rdchk(CMD, DN | FULL | 32'h0000_ffff);
        for (int k = 0; k < 2; k++) begin
            wrok(CMD, DIR | (k == 0 ? UP : DN) | (k == 0 ? 32'h0000_0020 : 32'h0000_0030));
            rd(DAT, v, r);
            idle();
            v = k == 0 ? 32'h0000_0021 : 32'h0000_002f;
            rdchk(CMD, DIR | (k == 0 ? UP : DN) | v);
            wrok(CMD, DIR | v);
            rdchk(DAT, exp_mem[v[7:0]]);
        end
        test_done();
    end
endmodule
